/* inc/clmp_pkg.sv */
/*
  constants, types and carriers for the control location and motor
  potentiometer block; assumes one 20 MHz clock and a power-on reset
*/
// Summary of operation
// - off mode keeps the drive stopped
// - hand entry copies drive reference, runs drive
// - restart during panel loss fault selects auto
// - local control obeys panel keys only
// - local disable bit blocks entering local
// - panel loss reaction selectable, local only
// - two external locations, own start/stop sources
// - operating mode chosen per external location
// - one binary source picks external location
// - reference source chosen per operating mode
// - local modes follow vector or scalar control
// - pot counter raised and lowered by signals
// - enabling pot loads configured initial value
// - pot value retained or reset per mode
// - pot rate is span over ramp time
// - up and down together hold value
// - pot output selectable as reference source
// - hand key in off starts, enters hand
// - hand key in external keeps drive running
// - off key stops, enters off unless local disabled
// - auto key in local selects external
package clmp_pkg;
  // ------------------------------------------------------------------
  // widths and timing
  // ------------------------------------------------------------------
  localparam int CLK_HZ       = 20_000_000;      // clk_sys rate
  localparam int TICK_US      = 1000;            // ramp time unit, us
  localparam int TICK_CYC_DEF = CLK_HZ / 1_000_000 * TICK_US;
  localparam int TCNT_W       = 16;              // tick counter width
  localparam int DIN_W        = 6;               // digital input pins
  localparam int FB_W         = 16;              // fieldbus word bits
  localparam int BIN_W        = DIN_W + FB_W;    // binary source pool
  localparam int IDX_W        = 5;               // binary source index
  localparam int REF_W        = 16;              // reference word
  localparam int REF_N_DEF    = 4;               // external refs
  localparam int RSEL_W       = 3;               // ref selector index

  // ------------------------------------------------------------------
  // enumerations
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    LOC_OFF  = 3'h1,   // local, off mode
    LOC_HAND = 3'h2,   // local, hand mode
    LOC_EXT  = 3'h4    // external control
  } clmp_loc_t;

  typedef enum logic [1:0] {
    OM_SPEED  = 2'h0,
    OM_TORQUE = 2'h1,
    OM_FREQ   = 2'h2
  } clmp_om_t;

  localparam logic [1:0] LA_NONE  = 2'h0; // ignore loss
  localparam logic [1:0] LA_FAULT = 2'h1; // trip and stop
  localparam logic [1:0] LA_LAST  = 2'h2; // hold last reference
  localparam logic [1:0] LA_SAFE  = 2'h3; // run at safe reference

  localparam logic [1:0] MPF_OFF    = 2'h0; // pot disabled
  localparam logic [1:0] MPF_RETAIN = 2'h1; // keep over power cycle
  localparam logic [1:0] MPF_RESET  = 2'h2; // reload over power cycle

  localparam logic [REF_W-1:0] REF_ZERO = 16'h0000;

  // ------------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic hand;        // hand key press, one cycle
    logic off;         // off key press, one cycle
    logic auto_k;      // auto key press, one cycle
  } clmp_key_t;

  typedef struct packed {
    logic                          local_dis;  // block local entry
    logic [1:0]                    loss_act;   // panel loss reaction
    clmp_om_t                      local_mode; // local operating mode
    logic                          scalar;     // 1 scalar, 0 vector
    logic [IDX_W-1:0]              ext_sel;    // second location source
    logic [1:0][IDX_W-1:0]         ext_start;  // start source per ext
    logic [1:0][IDX_W-1:0]         ext_stop;   // stop source per ext
    logic [1:0][1:0]               ext_mode;   // op mode per ext
    logic [2:0][RSEL_W-1:0]        ref_src;    // ref source per mode
    logic [REF_W-1:0]              safe_ref;   // loss safe reference
    logic [1:0]                    mp_func;    // pot function mode
    logic [IDX_W-1:0]              mp_up;      // pot up source
    logic [IDX_W-1:0]              mp_dn;      // pot down source
    logic [REF_W-1:0]              mp_init;    // pot initial value
    logic [REF_W-1:0]              mp_min;     // pot minimum
    logic [REF_W-1:0]              mp_max;     // pot maximum
    logic [REF_W-1:0]              mp_ramp;    // pot ramp time, ms
  } clmp_cfg_t;
endpackage : clmp_pkg

/* design/clmp_sync.sv */
/*
  three-stage input synchroniser for pins; output changes only when
  stages two and three agree; assumes pins are asynchronous to clk_sys
*/
`timescale 1ns/1ps
module clmp_sync
  import clmp_pkg::*;
#(
  parameter int W = DIN_W
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst,
  // pins in, clean levels out
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] lvl
);
  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] s1;   // metastable stage, read by s2 only
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;    // accepted level
  } clmp_sync_t;

  clmp_sync_t q, next_q;

  // shift and accept a bit once two settled stages agree
  always_comb begin
    next_q    = q;
    next_q.s1 = pin;
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
    next_q.q  = (q.s2 & q.s3) | (q.q & (q.s2 ^ q.s3));
  end

  // register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign lvl = q.q;
endmodule : clmp_sync

/* design/clmp_motpot.sv */
/*
  motor potentiometer counter with ramped rate and saturation; assumes
  a one-cycle tick every ramp time unit and a nonvolatile saved value
*/
`timescale 1ns/1ps
module clmp_motpot
  import clmp_pkg::*;
(
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // control
  input  wire logic             tick,    // one pulse per ms
  input  wire logic [1:0]       func,    // pot function mode
  input  wire logic             up,
  input  wire logic             dn,
  // limits and values
  input  wire logic [REF_W-1:0] init_v,
  input  wire logic [REF_W-1:0] min_v,
  input  wire logic [REF_W-1:0] max_v,
  input  wire logic [REF_W-1:0] ramp_ms,
  input  wire logic [REF_W-1:0] saved,   // value kept over power loss
  // result
  output logic      [REF_W-1:0] value
);
  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [REF_W-1:0] val;    // counter value
    logic [REF_W:0]   acc;    // rate accumulator
    logic             was_en; // enabled last cycle
    logic             fresh;  // no enable since power-up
  } clmp_mp_t;

  clmp_mp_t         q, next_q;
  logic [REF_W-1:0] span;     // max minus min
  logic             en;

  assign en   = (func != MPF_OFF);
  assign span = (max_v > min_v) ? max_v - min_v : REF_ZERO;

  // counter: acc gains span per ms and pays ramp per unit step, so the
  // full span takes exactly the ramp time
  always_comb begin
    next_q = q;
    if (!en) begin
      next_q.was_en = 1'b0;
      next_q.acc    = '0;
    end else if (!q.was_en) begin
      next_q.was_en = 1'b1;
      next_q.fresh  = 1'b0;
      next_q.acc    = '0;
      // first enable after power-up may restore the saved value
      if (q.fresh && func == MPF_RETAIN) begin
        next_q.val = saved;
      end else begin
        next_q.val = init_v;
      end
    end else if (up == dn) begin
      next_q.acc = '0;
    end else if (ramp_ms == REF_ZERO) begin
      next_q.val = up ? max_v : min_v;           // zero ramp jumps
    end else if ((up && q.val >= max_v) || (dn && q.val <= min_v)) begin
      next_q.val = up ? max_v : min_v;
      next_q.acc = '0;
    end else if (q.acc >= {1'b0, ramp_ms}) begin
      next_q.acc = q.acc - {1'b0, ramp_ms};
      next_q.val = up ? q.val + 16'h0001
                      : q.val - 16'h0001;
    end else if (tick) begin
      next_q.acc = q.acc + {1'b0, span};
    end
  end

  // register; fresh marks the power cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q <= '{val: '0, acc: '0, was_en: 1'b0, fresh: 1'b1};
    end else begin
      q <= next_q;
    end
  end

  assign value = q.val;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  hold_both_a: assert property (
    q.was_en && en && up && dn |=> $stable(q.val))
    else $error("pot moved with up and down both on");
  load_init_a: assert property (
    !q.fresh && en && !q.was_en |=> q.val == $past(init_v))
    else $error("pot enable did not load initial value");
  range_a: assert property (
    q.was_en && $past(q.was_en) && $stable(min_v) && $stable(max_v)
    && $past(q.val) <= max_v && q.val > max_v |-> 1'b0)
    else $error("pot value passed its maximum");
endmodule : clmp_motpot

/* design/clmp_top.sv */
/*
  control location selection (off, hand, external one and two) with
  reference and run command steering and a motor potentiometer;
  assumes key presses and panel link status come from same-clock panel
  logic, digital inputs are asynchronous pins
*/
`timescale 1ns/1ps
module clmp_top
  import clmp_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYC_DEF,  // cycles per ms
  parameter int REF_N    = REF_N_DEF      // external reference words
) (
  // clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        rst,
  // control panel
  input  wire clmp_key_t                   key,
  input  wire logic                        panel_link_ok,
  input  wire logic                        panel_ref_wr,
  input  wire logic [REF_W-1:0]            panel_ref,
  // drive logic
  input  wire logic                        restart,
  input  wire logic                        fault_reset,
  // external sources
  input  wire logic [DIN_W-1:0]            din_pin,
  input  wire logic [FB_W-1:0]             fb_cw,
  input  wire logic [REF_N-1:0][REF_W-1:0] ref_in,
  input  wire logic [REF_W-1:0]            mp_saved,
  // configuration
  input  wire clmp_cfg_t                   cfg,
  // status and commands
  output logic                             run_cmd,
  output logic                             loc_off,
  output logic                             loc_hand,
  output logic                             loc_ext,
  output logic                             second_loc_active,
  output logic [1:0]                       op_mode,
  output logic [RSEL_W-1:0]                ref_src,
  output logic [REF_W-1:0]                 ref_out,
  output logic                             panel_loss_fault,
  output logic [REF_W-1:0]                 mp_value
);
  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    clmp_loc_t         loc;       // control location
    logic              ext_run;   // external start latch
    logic              st_prev;   // start source, last cycle
    logic              e2;        // second external location active
    logic              run;       // run command
    logic              loss_flt;  // panel loss fault, sticky
    logic [1:0]        om;        // operating mode
    logic [RSEL_W-1:0] rsel;      // reference selector in use
    logic [REF_W-1:0]  local_ref; // hand mode reference
    logic [REF_W-1:0]  ref_v;     // drive reference
    logic [TCNT_W-1:0] tcnt;      // ms divider
    logic              tick;      // ms pulse
  } clmp_st_t;

  clmp_st_t         q, next_q;
  logic [DIN_W-1:0] din;          // synchronised inputs
  logic [BIN_W-1:0] bin;          // binary source pool
  logic             e2_sel;       // location select source
  logic             st_src;       // start of active location
  logic             sp_src;       // stop of active location
  logic             local_c;      // next location is local
  logic             lost;         // panel link lost in local
  logic [REF_W-1:0] sel_ref;      // reference from selectors

  // ------------------------------------------------------------------
  // sources
  // ------------------------------------------------------------------
  clmp_sync #(.W(DIN_W)) u_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pin     (din_pin),
    .lvl     (din)
  );

  assign bin = {fb_cw, din};

  // out-of-range index reads as an inactive source
  function automatic logic pick(input logic [BIN_W-1:0] v,
                                input logic [IDX_W-1:0] i);
    pick = (int'(i) < BIN_W) ? v[i] : 1'b0;
  endfunction : pick

  clmp_motpot u_mp (
    .clk_sys (clk_sys),
    .rst     (rst),
    .tick    (q.tick),
    .func    (cfg.mp_func),
    .up      (pick(bin, cfg.mp_up)),
    .dn      (pick(bin, cfg.mp_dn)),
    .init_v  (cfg.mp_init),
    .min_v   (cfg.mp_min),
    .max_v   (cfg.mp_max),
    .ramp_ms (cfg.mp_ramp),
    .saved   (mp_saved),
    .value   (mp_value)
  );

  // external selectors
  always_comb begin
    e2_sel = pick(bin, cfg.ext_sel);
    st_src = pick(bin, cfg.ext_start[e2_sel]);
    sp_src = pick(bin, cfg.ext_stop[e2_sel]);
  end

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    next_q         = q;
    next_q.st_prev = st_src;
    next_q.e2      = e2_sel;
    // ms divider
    next_q.tick    = 1'b0;
    if (int'(q.tcnt) >= TICK_CYC - 1) begin
      next_q.tcnt = '0;
      next_q.tick = 1'b1;
    end else begin
      next_q.tcnt = q.tcnt + 16'h0001;
    end

    // location machine; off beats hand beats auto
    case (q.loc)
      LOC_OFF: begin
        if (key.off) begin
          next_q.loc = LOC_OFF;
        end else if (key.hand) begin
          next_q.loc       = LOC_HAND;
          next_q.local_ref = q.ref_v;
        end else if (key.auto_k) begin
          next_q.loc = LOC_EXT;
        end
      end
      LOC_HAND: begin
        if (key.off) begin
          next_q.loc = LOC_OFF;
        end else if (key.auto_k) begin
          next_q.loc = LOC_EXT;
        end
      end
      LOC_EXT: begin
        if (key.off) begin
          next_q.ext_run = 1'b0;
          if (!cfg.local_dis) begin
            next_q.loc = LOC_OFF;
          end
        end else if (key.hand && !cfg.local_dis) begin
          next_q.loc       = LOC_HAND;
          next_q.local_ref = q.ref_v;
        end
      end
      default: begin
        next_q.loc = LOC_OFF;
      end
    endcase

    // a restart while tripped on panel loss hands control to auto
    if (restart && q.loss_flt) begin
      next_q.loc = LOC_EXT;
    end

    // external start latch, stop wins; fresh latch on entry
    if (next_q.loc != LOC_EXT || q.loc != LOC_EXT) begin
      next_q.ext_run = 1'b0;
    end else if (sp_src) begin
      next_q.ext_run = 1'b0;
    end else if (st_src && !q.st_prev) begin
      next_q.ext_run = 1'b1;
    end

    // panel loss reaction only acts in local; set wins over clear
    if (fault_reset) begin
      next_q.loss_flt = 1'b0;
    end
    if (lost && cfg.loss_act == LA_FAULT) begin
      next_q.loss_flt = 1'b1;
    end

    // panel reference write, honoured only in hand with a live link
    if (q.loc == LOC_HAND && next_q.loc == LOC_HAND && panel_ref_wr
        && panel_link_ok) begin
      next_q.local_ref = panel_ref;
    end

    // operating mode
    local_c = (next_q.loc != LOC_EXT);
    if (local_c) begin
      if (cfg.scalar) begin
        next_q.om = OM_FREQ;
      end else if (cfg.local_mode == OM_TORQUE) begin
        next_q.om = OM_TORQUE;
      end else begin
        next_q.om = OM_SPEED;
      end
    end else begin
      next_q.om = cfg.ext_mode[e2_sel];
    end
    next_q.rsel = cfg.ref_src[next_q.om];

    // run command: panel alone steers local, sources steer external
    case (next_q.loc)
      LOC_OFF:  next_q.run = 1'b0;
      LOC_HAND: next_q.run = !next_q.loss_flt;
      LOC_EXT:  next_q.run = next_q.ext_run;
      default:  next_q.run = 1'b0;
    endcase

    // reference
    if (local_c && lost && cfg.loss_act == LA_LAST) begin
      next_q.ref_v = q.ref_v;
    end else if (local_c && lost && cfg.loss_act == LA_SAFE) begin
      next_q.ref_v = cfg.safe_ref;
    end else if (local_c) begin
      next_q.ref_v = next_q.local_ref;
    end else begin
      next_q.ref_v = sel_ref;
    end
  end

  assign lost = (q.loc != LOC_EXT) && !panel_link_ok;

  // reference selector; the index past the inputs is the pot
  always_comb begin
    if (int'(cfg.ref_src[cfg.ext_mode[e2_sel]]) < REF_N) begin
      sel_ref = ref_in[cfg.ref_src[cfg.ext_mode[e2_sel]]];
    end else if (int'(cfg.ref_src[cfg.ext_mode[e2_sel]]) == REF_N) begin
      sel_ref = mp_value;
    end else begin
      sel_ref = REF_ZERO;
    end
  end

  // register; power-up in external with no run latched
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q     <= '0;
      q.loc <= LOC_EXT;
    end else begin
      q <= next_q;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign run_cmd          = q.run;
  assign loc_off          = (q.loc == LOC_OFF);
  assign loc_hand         = (q.loc == LOC_HAND);
  assign loc_ext          = (q.loc == LOC_EXT);
  assign second_loc_active = q.e2;
  assign op_mode          = q.om;
  assign ref_src          = q.rsel;
  assign ref_out          = q.ref_v;
  assign panel_loss_fault = q.loss_flt;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_hand_press;
    loc_off && key.hand && !key.off && !restart;
  endsequence
  sequence s_in_hand;
    loc_hand && (run_cmd == !panel_loss_fault);
  endsequence

  off_stopped_a: assert property (loc_off |-> !run_cmd)
    else $error("drive running in off mode");
  hand_ref_a: assert property (
    $rose(loc_hand) |-> q.local_ref == $past(ref_out))
    else $error("hand entry did not copy the reference");
  loss_auto_a: assert property (
    restart && panel_loss_fault |=> loc_ext)
    else $error("restart under panel loss stayed local");
  local_block_a: assert property (
    loc_ext && cfg.local_dis && !restart |=> loc_ext)
    else $error("entered local while disabled");
  hand_start_a: assert property (
    s_hand_press |=> s_in_hand)
    else $error("hand key in off did not start hand mode");
  hand_keep_a: assert property (
    loc_ext && run_cmd && key.hand && !key.off && !cfg.local_dis
    && !panel_loss_fault |=> loc_hand && run_cmd)
    else $error("hand key from external stopped the drive");
  off_key_a: assert property (
    key.off && !restart && !cfg.local_dis |=> loc_off ##0 !run_cmd)
    else $error("off key did not stop the drive");
  auto_key_a: assert property (
    !loc_ext && key.auto_k && !key.off && !key.hand |=> loc_ext)
    else $error("auto key did not select external");
  local_om_a: assert property (
    !loc_ext && cfg.scalar && $stable(cfg.scalar)
    |-> op_mode == OM_FREQ)
    else $error("local mode not frequency under scalar");
endmodule : clmp_top

/* dv/clmp_panel.sv */
/* keypad and terminal model: key pulses, fieldbus word, pins;
   assumes the bench calls its tasks from one thread */
`timescale 1ns/1ps
module clmp_panel
  import clmp_pkg::*;
(
  // clock
  input  wire logic             clk_sys,
  // sources towards the block
  output clmp_key_t             key,
  output logic      [FB_W-1:0]  fb_cw,
  output logic      [DIN_W-1:0] din_pin
);
  initial begin
    key     = '0;
    fb_cw   = '0;
    din_pin = '0;
  end
  // one-cycle press, launched off the sampling edge
  task automatic press(input clmp_key_t k);
    @(negedge clk_sys) key = k;
    @(negedge clk_sys) key = '0;
  endtask : press
  // control word change at a falling edge
  task automatic set_fb(input logic [FB_W-1:0] v);
    @(negedge clk_sys) fb_cw = v;
  endtask : set_fb
  // terminal pin levels change at a falling edge, half a cycle before the block samples them
  task automatic set_din(input logic [DIN_W-1:0] v);
    @(negedge clk_sys) din_pin = v;
  endtask : set_din
endmodule : clmp_panel

/* dv/clmp_top_test.sv */
/* self-checking bench for clmp_top; assumes clmp_panel as far side */
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin mismatches++; \
  $display("[ERR] %0t %h %h", $time, a, e); end end
module clmp_top_test;
  import clmp_pkg::*;
  logic clk_sys = 1'b0, rst = 1'b1, link = 1'b1, ref_wr = 1'b0;
  logic restart = 1'b0, fault_rst = 1'b0, panel_loss_fault;
  logic [REF_W-1:0] word = 16'h0000, saved = 16'h0000;
  clmp_key_t key;
  logic [FB_W-1:0] fb_cw;
  logic [DIN_W-1:0] din_pin;
  logic [3:0][REF_W-1:0] ref_in = '0;
  clmp_cfg_t cfg = '0;
  logic run_cmd, loc_off, loc_hand, loc_ext, second_loc_active;
  logic [1:0] op_mode;
  logic [RSEL_W-1:0] ref_src;
  logic [REF_W-1:0] mp_value, ref_out;
  int mismatches = 0, n_tests = 0;
  initial forever #25 clk_sys = ~clk_sys;
  clmp_panel clmp_panel_inst (.clk_sys(clk_sys), .key(key),
    .fb_cw(fb_cw), .din_pin(din_pin));
  clmp_top #(.TICK_CYC(20)) clmp_top_inst (.clk_sys(clk_sys), .rst(rst),
    .key(key), .panel_link_ok(link), .panel_ref_wr(ref_wr),
    .panel_ref(word), .restart(restart), .fault_reset(fault_rst),
    .din_pin(din_pin), .fb_cw(fb_cw), .ref_in(ref_in),
    .mp_saved(saved), .cfg(cfg), .run_cmd(run_cmd), .loc_off(loc_off),
    .loc_hand(loc_hand), .loc_ext(loc_ext),
    .second_loc_active(second_loc_active), .op_mode(op_mode),
    .ref_src(ref_src), .ref_out(ref_out),
    .panel_loss_fault(panel_loss_fault), .mp_value(mp_value));
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc
  task automatic complete_run();
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run
  // key walk through every location
  task automatic t_keys();
    clmp_panel_inst.press(3'h4); cyc(1);
    `CHK({loc_hand, run_cmd}, 2'h3)
    clmp_panel_inst.press(3'h2); cyc(1);
    `CHK({loc_off, run_cmd}, 2'h2)
    clmp_panel_inst.press(3'h4); cyc(1);
    `CHK({loc_hand, run_cmd}, 2'h3)
    clmp_panel_inst.press(3'h1); cyc(1);
    `CHK(loc_ext, 1'b1)
  endtask : t_keys
  // local entry blocked by the disable bit
  task automatic t_disable();
    cfg.local_dis = 1'b1;
    clmp_panel_inst.press(3'h4); cyc(1);
    `CHK(loc_ext, 1'b1)
    cfg.local_dis = 1'b0;
  endtask : t_disable
  // second location picked by a control word bit, bounded wait
  task automatic t_second_external_location();
    int i;
    clmp_panel_inst.set_fb(16'h0001);
    for (i = 0; i < 10 && second_loc_active !== 1'b1; i++) cyc(1);
    `CHK(second_loc_active, 1'b1)
    cyc(1);
    `CHK(op_mode, 2'h1)
    clmp_panel_inst.set_fb(16'h0000);
    cyc(3);
    `CHK(op_mode, 2'h0)
  endtask : t_second_external_location
  // pot load, climb to max, hold, fall to min
  task automatic t_pot();
    cfg.mp_func = MPF_RESET; cyc(3);
    `CHK(mp_value, 16'h000f)
    clmp_panel_inst.set_fb(16'h0008); cyc(150);
    `CHK(mp_value, 16'h0014)
    clmp_panel_inst.set_fb(16'h0018); cyc(60);
    `CHK(mp_value, 16'h0014)
    clmp_panel_inst.set_fb(16'h0010); cyc(150);
    `CHK(mp_value, 16'h000a)
  endtask : t_pot
  // reference per mode, pot as source, hand copy, panel write
  task automatic t_ref();
    ref_in[0] = 16'h1234; cfg.ref_src[1] = 3'h4;
    clmp_panel_inst.set_fb(16'h0000); cyc(2);
    `CHK({ref_src, ref_out}, {3'h0, 16'h1234})
    clmp_panel_inst.set_fb(16'h0001); cyc(2);
    `CHK({ref_src, ref_out}, {3'h4, 16'h000a})
    clmp_panel_inst.set_fb(16'h0000); cyc(2);
    clmp_panel_inst.press(3'h4); cyc(1);
    `CHK(ref_out, 16'h1234)
    word = 16'h0abc; ref_wr = 1'b1; ref_in[0] = 16'h5555; cyc(1);
    ref_wr = 1'b0; cyc(1);
    `CHK(ref_out, 16'h0abc)
  endtask : t_ref
  // panel loss reactions in hand, restart to auto, none in external
  task automatic t_loss();
    cfg.safe_ref = 16'h0777; cfg.loss_act = LA_SAFE; link = 1'b0; cyc(2);
    `CHK(ref_out, 16'h0777)
    cfg.loss_act = LA_LAST; cyc(2);
    `CHK(ref_out, 16'h0777)
    cfg.loss_act = LA_FAULT; cyc(2);
    `CHK({panel_loss_fault, run_cmd}, 2'h2)
    link = 1'b1; restart = 1'b1; cyc(1);
    restart = 1'b0;
    `CHK(loc_ext, 1'b1)
    fault_rst = 1'b1; cyc(1);
    fault_rst = 1'b0;
    `CHK(panel_loss_fault, 1'b0)
    link = 1'b0; cyc(3);
    `CHK(panel_loss_fault, 1'b0)
    link = 1'b1; cfg.loss_act = LA_NONE;
  endtask : t_loss
  // pin start, hand keeps running, local modes, second location run
  task automatic t_run();
    clmp_panel_inst.set_din(6'h01); cyc(6);
    `CHK(run_cmd, 1'b1)
    clmp_panel_inst.press(3'h4); cyc(1);
    `CHK({loc_hand, run_cmd}, 2'h3)
    cfg.scalar = 1'b1; cyc(2);
    `CHK(op_mode, 2'h2)
    cfg.scalar = 1'b0; cfg.local_mode = OM_TORQUE; cyc(2);
    `CHK(op_mode, 2'h1)
    clmp_panel_inst.press(3'h1);
    clmp_panel_inst.set_din(6'h02); cyc(6);
    `CHK(run_cmd, 1'b0)
    clmp_panel_inst.set_fb(16'h0001);
    clmp_panel_inst.set_fb(16'h0003); cyc(1);
    `CHK({second_loc_active, run_cmd}, 2'h3)
    clmp_panel_inst.set_fb(16'h0007); cyc(1);
    `CHK(run_cmd, 1'b0)
    cfg.local_mode = OM_SPEED;
    clmp_panel_inst.set_fb(16'h0000);
    clmp_panel_inst.set_din(6'h00); cyc(6);
  endtask : t_run
  // mid-run resets: pot retained in one mode, reloaded in the other
  task automatic t_rst();
    cfg.mp_func = MPF_RETAIN; saved = 16'h0011; cyc(6);
    rst = 1'b1; cyc(2);
    rst = 1'b0; cyc(2);
    `CHK({loc_ext, run_cmd, mp_value}, {2'h2, 16'h0011})
    cfg.mp_func = MPF_RESET; rst = 1'b1; cyc(2);
    rst = 1'b0; cyc(2);
    `CHK(mp_value, 16'h000f)
  endtask : t_rst
  initial begin
    cfg.ext_sel = 5'h06; cfg.ext_start = {5'h07, 5'h00};
    cfg.ext_stop = {5'h08, 5'h01}; cfg.ext_mode = {2'h1, 2'h0};
    cfg.mp_up = 5'h09; cfg.mp_dn = 5'h0a; cfg.mp_init = 16'h000f;
    cfg.mp_min = 16'h000a; cfg.mp_max = 16'h0014; cfg.mp_ramp = 16'h0001;
    cyc(16);
    rst = 1'b0;
    cyc(1);
    `CHK({loc_ext, loc_off, loc_hand, run_cmd}, 4'h8)
    t_keys();
    t_disable();
    t_second_external_location();
    t_pot();
    t_ref();
    t_loss();
    t_run();
    t_rst();
    complete_run();
  end
endmodule : clmp_top_test
